// ---- common/slc_pkg.sv ----
// Constants, types and register map of the segment display scan block.
// Assumes one 25 MHz system clock and an APB master with 32-bit data.
//
// Operation
// - Dead-zone field n blanks n/32 of each LED common beat; zero none.
// - Segment-allow zero holds segments off; one lets buffered data through.
// - Segment-allow acts only in LCD and digit LED modes, not matrix.
// - Pad drive enable zero puts every common and segment pad high-Z.
// - While refresh reads zero the buffer holds; data writes stay unseen.
// - Writing refresh one copies data into buffer, then bit self-clears.
// - Codes 0-7: LCD with 3,4,5,6 commons; even frame, odd row invert.
// - Codes 8,9 four-common digit LED; code 10 eight-common digit LED.
// - Codes 12,13 seven-pin matrix LED; codes 14,15 eight-pin matrix.
// - LCD modes: first data register bits 23..0 are common 0 segments.
// - LCD modes: second data register bits 23..0 are common 1 segments.
// - LED modes: byte k of first data register drives common k.
// - LED modes: byte k of second data register drives common k+4.
// - A one bit lights its segment in its common period; zero is off.
// - Scan timing runs from fast or slow oscillator, software selects.
package slc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  OFF_CTRL        = 8'h00;
   localparam logic [7:0]  OFF_DATA0       = 8'h04;
   localparam logic [7:0]  OFF_DATA1       = 8'h08;
   localparam logic [7:0]  OFF_CLKSEL      = 8'h24;
   localparam logic [31:0] RST_CTRL        = 32'h0000_0000;
   localparam logic [31:0] RST_DATA        = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK      = 32'h0000_07AF;
   localparam logic [31:0] CLKSEL_WMASK    = 32'h0000_0001;
   localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Geometry and mode codes
   // ----------------------------------------------------------------
   localparam int          SLOTS_PER_BEAT  = 32;
   localparam int          SLOT_W          = 5;
   localparam int          DZ_W            = 3;
   localparam int          COM_PINS        = 8;
   localparam int          SEG_PINS        = 24;
   localparam int          LED_SEGS        = 8;
   localparam logic [3:0]  LCD_COM_BASE    = 4'h3;
   localparam logic [3:0]  DIGIT_COMS_LO   = 4'h4;
   localparam logic [3:0]  DIGIT_COMS_HI   = 4'h8;
   localparam logic [3:0]  MATRIX_PINS_LO  = 4'h7;
   localparam logic [3:0]  MATRIX_PINS_HI  = 4'h8;
   localparam logic [3:0]  MODE_LCD_LAST   = 4'h7;
   localparam logic [3:0]  MODE_DIGIT8     = 4'hA;
   localparam logic [3:0]  MODE_MATRIX7    = 4'hC;
   localparam logic [3:0]  MODE_MATRIX8    = 4'hE;

   typedef struct packed {
      logic [20:0] rsv_hi;
      logic [2:0]  common_dead_zone;
      logic        segment_output_allow;
      logic        rsv6;
      logic        pad_drive_enable;
      logic        buffer_update_request;
      logic [3:0]  mode;
   } slc_ctrl_t;

   typedef enum logic [2:0] {
      CLS_LCD    = 3'b001,
      CLS_DIGIT  = 3'b010,
      CLS_MATRIX = 3'b100
   } slc_class_t;

   typedef enum logic [1:0] {
      ST_DRIVE = 2'b01,
      ST_DEAD  = 2'b10
   } slc_state_t;

endpackage

// ---- logic/slc_beat_timer.sv ----
// Beat timer: picks fast or slow oscillator, cuts each common beat
// into 32 slots and flags the leading dead-zone slots.
// Assumes oscillator inputs are asynchronous to clk_in.
module slc_beat_timer #(
   parameter int SLOT_TICKS = 4
) (
   input  wire logic                      clk_in,
   input  wire logic                      rst_in,
   input  wire logic                      fast_osc_in,
   input  wire logic                      slow_osc_in,
   input  wire logic                      use_slow_in,
   input  wire logic [slc_pkg::DZ_W-1:0]  dead_zone_in,
   output logic                           beat_end_out,
   output logic                           dead_out
);

   if (SLOT_TICKS < 1 || SLOT_TICKS > 65535) begin : g_bad_ticks
      $error("SLOT_TICKS out of range");
   end

   // ----------------------------------------------------------------
   // Synchronisers and tick counting
   // ----------------------------------------------------------------
   logic [1:0]                 sync1_reg, sync1_next;
   logic [1:0]                 sync2_reg, sync2_next;
   logic [1:0]                 sync3_reg, sync3_next;
   logic [15:0]                tick_reg, tick_next;
   logic [slc_pkg::SLOT_W-1:0] slot_reg, slot_next;
   logic                       edge_seen;
   logic                       slot_wrap;

   always_comb begin
      sync1_next = {slow_osc_in, fast_osc_in};
      sync2_next = sync1_reg;
      sync3_next = sync2_reg;
      // The second and third stages feed the edge detector
      edge_seen  = use_slow_in ? (sync2_reg[1] & ~sync3_reg[1])
                               : (sync2_reg[0] & ~sync3_reg[0]);
      slot_wrap  = edge_seen && (tick_reg == 16'(SLOT_TICKS - 1));
      tick_next  = tick_reg;
      slot_next  = slot_reg;
      if (edge_seen) begin
         tick_next = slot_wrap ? 16'h0000 : tick_reg + 16'h0001;
      end
      if (slot_wrap) begin
         slot_next = slot_reg + 5'h01;
      end
      beat_end_out = slot_wrap &&
         (slot_reg == 5'(slc_pkg::SLOTS_PER_BEAT - 1));
      // Look one slot ahead so the registered dead state meets the beat
      dead_out     = {2'b00, dead_zone_in} > slot_next;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
         sync3_reg <= 2'h0;
         tick_reg  <= 16'h0000;
         slot_reg  <= 5'h00;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         sync3_reg <= sync3_next;
         tick_reg  <= tick_next;
         slot_reg  <= slot_next;
      end
   end

endmodule

// ---- logic/slc_scan_ctrl.sv ----
// Segment LCD / LED scan controller top: APB registers, display
// buffer, common scan sequencer and registered pad drivers.
// Assumes an APB master on CLK_IN and pads resolved outside.
//
// The implementer's own choice: the APB interface to the registers.
module slc_scan_ctrl #(
   parameter int SLOT_TICKS = 4
) (
   input  wire logic                         CLK_IN,
   input  wire logic                         RST_IN,
   input  wire logic                         PSEL_IN,
   input  wire logic                         PENABLE_IN,
   input  wire logic                         PWRITE_IN,
   input  wire logic [slc_pkg::ADDR_W-1:0]   PADDR_IN,
   input  wire logic [31:0]                  PWDATA_IN,
   output logic      [31:0]                  PRDATA_OUT,
   output logic                              PREADY_OUT,
   output logic                              PSLVERR_OUT,
   input  wire logic                         FAST_OSC_IN,
   input  wire logic                         SLOW_OSC_IN,
   output logic      [slc_pkg::COM_PINS-1:0] COM_OUT,
   output logic      [slc_pkg::COM_PINS-1:0] COM_OE_N_OUT,
   output logic      [slc_pkg::SEG_PINS-1:0] SEG_OUT,
   output logic      [slc_pkg::SEG_PINS-1:0] SEG_OE_N_OUT
);

   localparam int CP = slc_pkg::COM_PINS;
   localparam int SP = slc_pkg::SEG_PINS;

   slc_pkg::slc_ctrl_t  ctrl_reg, ctrl_next;
   logic [31:0]         data0_reg, data0_next;
   logic [31:0]         data1_reg, data1_next;
   logic [31:0]         buf0_reg, buf0_next;
   logic [31:0]         buf1_reg, buf1_next;
   logic                use_slow_reg, use_slow_next;
   logic [31:0]         prdata_reg, prdata_next;
   logic                pready_reg, pready_next;
   logic                pslverr_reg, pslverr_next;
   logic                wr_take;
   logic                mapped;
   logic                set_refresh;
   logic                beat_end;
   logic                dead;
   logic                frame_end;

   // ----------------------------------------------------------------
   // Beat timing
   // ----------------------------------------------------------------
   slc_beat_timer #(
      .SLOT_TICKS   (SLOT_TICKS)
   ) u_timer (
      .clk_in       (CLK_IN),
      .rst_in       (RST_IN),
      .fast_osc_in  (FAST_OSC_IN),
      .slow_osc_in  (SLOW_OSC_IN),
      .use_slow_in  (use_slow_reg),
      .dead_zone_in (ctrl_reg.common_dead_zone),
      .beat_end_out (beat_end),
      .dead_out     (dead)
   );

   // ----------------------------------------------------------------
   // APB slave and registers
   // ----------------------------------------------------------------
   always_comb begin
      mapped = (PADDR_IN == slc_pkg::OFF_CTRL)  ||
               (PADDR_IN == slc_pkg::OFF_DATA0) ||
               (PADDR_IN == slc_pkg::OFF_DATA1) ||
               (PADDR_IN == slc_pkg::OFF_CLKSEL);
      // One wait state: ready rises in the second access cycle
      pready_next  = PSEL_IN && PENABLE_IN && !pready_reg;
      pslverr_next = pready_next && !mapped;
      wr_take      = PSEL_IN && PENABLE_IN && pready_reg && PWRITE_IN;
      prdata_next  = slc_pkg::READ_ZERO;
      if (pready_next && !PWRITE_IN) begin
         case (PADDR_IN)
            slc_pkg::OFF_CTRL:   prdata_next = ctrl_reg;
            slc_pkg::OFF_DATA0:  prdata_next = data0_reg;
            slc_pkg::OFF_DATA1:  prdata_next = data1_reg;
            slc_pkg::OFF_CLKSEL: prdata_next = {31'h0, use_slow_reg};
            default:             prdata_next = slc_pkg::READ_ZERO;
         endcase
      end
      set_refresh = wr_take && (PADDR_IN == slc_pkg::OFF_CTRL) &&
                    PWDATA_IN[4];
      ctrl_next     = ctrl_reg;
      data0_next    = data0_reg;
      data1_next    = data1_reg;
      use_slow_next = use_slow_reg;
      if (wr_take) begin
         case (PADDR_IN)
            slc_pkg::OFF_CTRL:   ctrl_next = PWDATA_IN & slc_pkg::CTRL_WMASK;
            slc_pkg::OFF_DATA0:  data0_next = PWDATA_IN;
            slc_pkg::OFF_DATA1:  data1_next = PWDATA_IN;
            slc_pkg::OFF_CLKSEL: use_slow_next = PWDATA_IN[0];
            default:             ctrl_next = ctrl_reg;
         endcase
      end
      // Set wins over the self-clear; a late request takes next frame
      ctrl_next.buffer_update_request = set_refresh ||
         (ctrl_reg.buffer_update_request && !frame_end);
      buf0_next = buf0_reg;
      buf1_next = buf1_reg;
      if (ctrl_reg.buffer_update_request && frame_end) begin
         buf0_next = data0_reg;
         buf1_next = data1_reg;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         ctrl_reg     <= slc_pkg::RST_CTRL;
         data0_reg    <= slc_pkg::RST_DATA;
         data1_reg    <= slc_pkg::RST_DATA;
         buf0_reg     <= slc_pkg::RST_DATA;
         buf1_reg     <= slc_pkg::RST_DATA;
         use_slow_reg <= 1'b0;
         prdata_reg   <= slc_pkg::READ_ZERO;
         pready_reg   <= 1'b0;
         pslverr_reg  <= 1'b0;
      end else begin
         ctrl_reg     <= ctrl_next;
         data0_reg    <= data0_next;
         data1_reg    <= data1_next;
         buf0_reg     <= buf0_next;
         buf1_reg     <= buf1_next;
         use_slow_reg <= use_slow_next;
         prdata_reg   <= prdata_next;
         pready_reg   <= pready_next;
         pslverr_reg  <= pslverr_next;
      end
   end

   assign PRDATA_OUT  = prdata_reg;
   assign PREADY_OUT  = pready_reg;
   assign PSLVERR_OUT = pslverr_reg;

   // ----------------------------------------------------------------
   // Mode decode and common scan sequencer
   // ----------------------------------------------------------------
   slc_pkg::slc_class_t cls;
   slc_pkg::slc_state_t state_reg, state_next;
   logic [2:0]          com_idx_reg, com_idx_next;
   logic                frame_inv_reg, frame_inv_next;
   logic                row_inv_reg, row_inv_next;
   logic [3:0]          ncoms;
   logic [3:0]          mode;

   always_comb begin
      mode = ctrl_reg.mode;
      if (mode <= slc_pkg::MODE_LCD_LAST) begin
         cls   = slc_pkg::CLS_LCD;
         ncoms = slc_pkg::LCD_COM_BASE + {2'b00, mode[2:1]};
      end else if (mode < slc_pkg::MODE_DIGIT8) begin
         cls   = slc_pkg::CLS_DIGIT;
         ncoms = slc_pkg::DIGIT_COMS_LO;
      end else if (mode < slc_pkg::MODE_MATRIX7) begin
         cls   = slc_pkg::CLS_DIGIT;
         ncoms = slc_pkg::DIGIT_COMS_HI;
      end else if (mode < slc_pkg::MODE_MATRIX8) begin
         cls   = slc_pkg::CLS_MATRIX;
         ncoms = slc_pkg::MATRIX_PINS_LO;
      end else begin
         cls   = slc_pkg::CLS_MATRIX;
         ncoms = slc_pkg::MATRIX_PINS_HI;
      end
      frame_end = beat_end && ({1'b0, com_idx_reg} >= ncoms - 4'h1);
      com_idx_next   = com_idx_reg;
      frame_inv_next = frame_inv_reg;
      row_inv_next   = row_inv_reg;
      if (beat_end) begin
         com_idx_next = frame_end ? 3'h0 : com_idx_reg + 3'h1;
         row_inv_next = !row_inv_reg;
      end
      if (frame_end) begin
         frame_inv_next = !frame_inv_reg;
      end
      // LCD waveforms carry no dead zone
      case (state_reg)
         slc_pkg::ST_DRIVE: state_next = (dead && cls != slc_pkg::CLS_LCD)
                               ? slc_pkg::ST_DEAD : slc_pkg::ST_DRIVE;
         slc_pkg::ST_DEAD:  state_next = (dead && cls != slc_pkg::CLS_LCD)
                               ? slc_pkg::ST_DEAD : slc_pkg::ST_DRIVE;
         default:           state_next = slc_pkg::ST_DRIVE;
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         state_reg     <= slc_pkg::ST_DRIVE;
         com_idx_reg   <= 3'h0;
         frame_inv_reg <= 1'b0;
         row_inv_reg   <= 1'b0;
      end else begin
         state_reg     <= state_next;
         com_idx_reg   <= com_idx_next;
         frame_inv_reg <= frame_inv_next;
         row_inv_reg   <= row_inv_next;
      end
   end

   // ----------------------------------------------------------------
   // Pad drivers
   // ----------------------------------------------------------------
   logic [31:0]  led_word;
   logic [7:0]   led_byte;
   logic [SP-1:0] lcd_word;
   logic         lcd_inv;
   logic         seg_gate;
   logic         drive;
   logic [CP-1:0] com_next, com_oe_n_next;
   logic [SP-1:0] seg_next, seg_oe_n_next;
   logic [CP-1:0] com_reg, com_oe_n_reg;
   logic [SP-1:0] seg_reg, seg_oe_n_reg;

   always_comb begin
      led_word = com_idx_reg[2] ? buf1_reg : buf0_reg;
      led_byte = led_word[{com_idx_reg[1:0], 3'b000} +: 8];
      case (com_idx_reg)
         3'h0:    lcd_word = buf0_reg[SP-1:0];
         3'h1:    lcd_word = buf1_reg[SP-1:0];
         default: lcd_word = '0;
      endcase
      lcd_inv  = mode[0] ? row_inv_reg : frame_inv_reg;
      seg_gate = (cls == slc_pkg::CLS_MATRIX) ||
                 ctrl_reg.segment_output_allow;
      drive    = (state_reg == slc_pkg::ST_DRIVE);
   end

   for (genvar k = 0; k < CP; k++) begin : g_com
      logic used;
      logic sel;
      always_comb begin
         used = (4'(k) < ncoms);
         sel  = (3'(k) == com_idx_reg);
         case (cls)
            slc_pkg::CLS_LCD:    com_next[k] = used && (sel ^ lcd_inv);
            // Cathode polarity: active common pulled low
            slc_pkg::CLS_DIGIT:  com_next[k] = !(used && sel && drive);
            slc_pkg::CLS_MATRIX: com_next[k] = used &&
               (sel ? !drive : (led_byte[k] && drive));
            default:             com_next[k] = 1'b0;
         endcase
         com_oe_n_next[k] = !(ctrl_reg.pad_drive_enable && used);
      end
   end

   for (genvar j = 0; j < SP; j++) begin : g_seg
      logic used;
      always_comb begin
         used = (cls == slc_pkg::CLS_LCD) ||
                (cls == slc_pkg::CLS_DIGIT && j < slc_pkg::LED_SEGS);
         case (cls)
            slc_pkg::CLS_LCD:   seg_next[j] =
               (lcd_word[j] && seg_gate) ^ lcd_inv;
            slc_pkg::CLS_DIGIT: seg_next[j] = (j < slc_pkg::LED_SEGS) &&
               led_byte[j % slc_pkg::LED_SEGS] && seg_gate && drive;
            default:            seg_next[j] = 1'b0;
         endcase
         seg_oe_n_next[j] = !(ctrl_reg.pad_drive_enable && used);
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         com_reg      <= '0;
         com_oe_n_reg <= '1;
         seg_reg      <= '0;
         seg_oe_n_reg <= '1;
      end else begin
         com_reg      <= com_next;
         com_oe_n_reg <= com_oe_n_next;
         seg_reg      <= seg_next;
         seg_oe_n_reg <= seg_oe_n_next;
      end
   end

   assign COM_OUT      = com_reg;
   assign COM_OE_N_OUT = com_oe_n_reg;
   assign SEG_OUT      = seg_reg;
   assign SEG_OE_N_OUT = seg_oe_n_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   a_dz_none: assert property (
      (ctrl_reg.common_dead_zone == 3'h0) [*2] |-> drive)
      else $error("dead slot without dead zone");
   a_seg_forced_off: assert property (
      (cls == slc_pkg::CLS_DIGIT && !ctrl_reg.segment_output_allow)
      |=> SEG_OUT == '0)
      else $error("digit segment lit while not allowed");
   a_lcd_seg_gate: assert property (
      (cls == slc_pkg::CLS_LCD && !ctrl_reg.segment_output_allow)
      |=> SEG_OUT == {SP{$past(lcd_inv)}})
      else $error("lcd segment data leaked while off");
   a_pad_hiz: assert property (
      !ctrl_reg.pad_drive_enable |=> (&COM_OE_N_OUT) && (&SEG_OE_N_OUT))
      else $error("pad driven while disabled");
   a_buf_hold: assert property (
      !ctrl_reg.buffer_update_request |=> $stable(buf0_reg) &&
      $stable(buf1_reg))
      else $error("buffer changed without refresh");
   a_refresh_done: assert property (
      ctrl_reg.buffer_update_request && frame_end && !set_refresh
      |=> !ctrl_reg.buffer_update_request &&
          buf0_reg == $past(data0_reg) && buf1_reg == $past(data1_reg))
      else $error("refresh copy or self-clear missing");
   a_lcd_com_count: assert property (
      beat_end && cls == slc_pkg::CLS_LCD && !wr_take
      |=> {1'b0, com_idx_reg} < ncoms)
      else $error("lcd common index beyond count");
   a_digit_one_com: assert property (
      cls == slc_pkg::CLS_DIGIT |=> $countones(~COM_OUT) <= 1)
      else $error("more than one digit common active");
   a_matrix7_pin: assert property (
      mode == slc_pkg::MODE_MATRIX7 |=> COM_OE_N_OUT[CP-1])
      else $error("eighth pin driven in seven-pin mode");
   a_lcd_com0_data: assert property (
      cls == slc_pkg::CLS_LCD && com_idx_reg == 3'h0 && seg_gate
      |=> SEG_OUT == ($past(buf0_reg[SP-1:0]) ^ {SP{$past(lcd_inv)}}))
      else $error("lcd common 0 segments wrong");
   a_led_byte_map: assert property (
      cls == slc_pkg::CLS_DIGIT && drive && seg_gate && !com_idx_reg[2]
      |=> SEG_OUT[7:0] ==
          $past(buf0_reg[{com_idx_reg[1:0], 3'b000} +: 8]))
      else $error("led segment byte mismatch");

   c_refresh: cover property (
      set_refresh ##[1:1000] !ctrl_reg.buffer_update_request);
   c_dead: cover property (state_reg == slc_pkg::ST_DEAD);
   c_matrix: cover property (cls == slc_pkg::CLS_MATRIX && beat_end);
   c_read: cover property (pready_reg && !PWRITE_IN && !pslverr_reg);

endmodule

// ---- test/segment_lcd_led_scan_control_tb.sv ----
// Testbench: APB master, oscillators and LED model around the block.
// Assumes SLOT_TICKS 1, so a four-common digit frame on the fast oscillator is 512 clocks.
module segment_lcd_led_scan_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, psel, pen, pwr, fosc, sosc, clr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, er;
   logic [7:0]  com, com_oe_n;
   logic [23:0] seg, seg_oe_n;
   logic [7:0][7:0] seen;
   logic [2:0]  div;
   int fail_count = 0;
   int n_compared = 0;
   slc_scan_ctrl #(.SLOT_TICKS(1)) dut (.CLK_IN(clk), .RST_IN(rst),
      .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .FAST_OSC_IN(fosc), .SLOW_OSC_IN(sosc),
      .COM_OUT(com), .COM_OE_N_OUT(com_oe_n), .SEG_OUT(seg),
      .SEG_OE_N_OUT(seg_oe_n));
   slc_led_model far (.clk_in(clk), .clr_in(clr), .com_in(com),
      .com_oe_n_in(com_oe_n), .seg_in(seg), .seg_oe_n_in(seg_oe_n),
      .seen_out(seen));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Fast oscillator at a quarter of the clock, slow one slower still
   always_ff @(posedge clk) begin
      if (rst) begin
         div <= 3'h0;
         fosc <= 1'b0;
         sosc <= 1'b0;
      end else begin
         div <= div + 3'h1;
         fosc <= div[1];
         sosc <= div[2];
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      // Only the watchdog ends a wait for ready
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic show(input logic [31:0] d0, input logic [31:0] d1);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (1100) @(posedge clk);
      chk({seen[3], seen[2], seen[1], seen[0]}, d0);
      chk({seen[7], seen[6], seen[5], seen[4]}, d1);
   endtask
   task automatic refresh(input logic [31:0] c);
      int n;
      apb(1'b1, slc_pkg::OFF_CTRL, c);
      n = 0;
      rd = 32'h0000_0010;
      while (rd[4] !== 1'b0 && n < 400) begin
         apb(1'b0, slc_pkg::OFF_CTRL, 32'h0000_0000);
         n++;
      end
      chk({31'h0, rd[4]}, 32'h0000_0000);
   endtask
   task automatic t_reset;
      apb(1'b0, slc_pkg::OFF_CTRL, 32'h0);
      chk(rd, slc_pkg::RST_CTRL);
      apb(1'b0, slc_pkg::OFF_DATA1, 32'h0);
      chk(rd, slc_pkg::RST_DATA);
      chk({com_oe_n, seg_oe_n}, 32'hFFFF_FFFF);
      apb(1'b0, 8'h10, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      $display("test reset done");
   endtask
   task automatic t_scan;
      apb(1'b1, slc_pkg::OFF_DATA0, 32'hA5C3_0F81);
      apb(1'b1, slc_pkg::OFF_DATA1, 32'h1E69_F007);
      apb(1'b0, slc_pkg::OFF_DATA1, 32'h0);
      chk(rd, 32'h1E69_F007);
      refresh(32'h0000_03B8);
      // Four-common mode never scans commons 4 to 7
      show(32'hA5C3_0F81, 32'h0000_0000);
      apb(1'b1, slc_pkg::OFF_DATA0, 32'h5A3C_F07E);
      show(32'hA5C3_0F81, 32'h0000_0000);
      refresh(32'h0000_00BA);
      show(32'h5A3C_F07E, 32'h1E69_F007);
      $display("test scan done");
   endtask
   task automatic t_clk;
      apb(1'b1, slc_pkg::OFF_CLKSEL, 32'h0000_0001);
      apb(1'b0, slc_pkg::OFF_CLKSEL, 32'h0);
      chk(rd, 32'h0000_0001);
      refresh(32'h0000_00B8);
      show(32'h5A3C_F07E, 32'h0000_0000);
      $display("test clock source done");
   endtask
   task automatic t_gate;
      apb(1'b1, slc_pkg::OFF_CTRL, 32'h0000_0028);
      repeat (300) @(posedge clk);
      chk({8'h0, seg}, 32'h0);
      apb(1'b1, slc_pkg::OFF_CTRL, 32'h0000_00A0);
      repeat (8) @(posedge clk);
      chk({com_oe_n, seg_oe_n}, 32'hF800_0000);
      apb(1'b1, slc_pkg::OFF_CTRL, 32'h0000_002C);
      repeat (8) @(posedge clk);
      chk({com_oe_n, seg_oe_n}, 32'h80FF_FFFF);
      apb(1'b1, slc_pkg::OFF_CTRL, 32'h0000_0088);
      repeat (8) @(posedge clk);
      chk({com_oe_n, seg_oe_n}, 32'hFFFF_FFFF);
      $display("test gate done");
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      clr = 1'b0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_scan;
      t_clk;
      t_gate;
      report_and_stop;
   end
   initial begin
      #(40 * 30000);
      fail_count++;
      report_and_stop;
   end
endmodule

// ---- test/slc_led_model.sv ----
// Far-side model: common and segment lines of an LED digit display.
// Assumes pads registered on clk_in; undriven lines float.
module slc_led_model (
   input  wire logic            clk_in,
   input  wire logic            clr_in,
   input  wire logic [7:0]      com_in,
   input  wire logic [7:0]      com_oe_n_in,
   input  wire logic [23:0]     seg_in,
   input  wire logic [23:0]     seg_oe_n_in,
   output logic      [7:0][7:0] seen_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  com_w;
   logic [7:0]  com_last;
   logic [23:0] seg_w;
   logic [23:0] seg_last;
   // Floating line shows inverse of last driven level
   assign com_w = (~com_oe_n_in & com_in) | (com_oe_n_in & ~com_last);
   assign seg_w = (~seg_oe_n_in & seg_in) | (seg_oe_n_in & ~seg_last);
   always_ff @(posedge clk_in) begin
      if (clr_in) begin
         com_last <= '0;
         seg_last <= '0;
         seen_out <= '0;
      end else begin
         com_last <= (~com_oe_n_in & com_in) | (com_oe_n_in & com_last);
         seg_last <= (~seg_oe_n_in & seg_in) | (seg_oe_n_in & seg_last);
      end
      if (!clr_in && $onehot(~com_w)) begin
         // One low common lights its byte; dead slots record nothing
         for (int k = 0; k < 8; k++) begin
            if (!com_w[k]) begin
               seen_out[k] <= seg_w[7:0];
            end
         end
      end
   end
endmodule
